// >>> core/mbox_defines.svh
// Mailbox addresses, field positions and reset values
`ifndef MBOX_DEFINES_SVH
`define MBOX_DEFINES_SVH

// ****************************************
// DSP side register addresses
// ****************************************
`define DSP_HOST_CMD    16'hD140
`define DSP_HOST_BUSY   16'hD141
`define DSP_HOST_GEN_LO 16'hD142
`define DSP_HOST_GEN_HI 16'hD143
`define DSP_HOST_GEN    16'hD144
`define DSP_TX_COUNT    16'hD150
`define DSP_IRQ_STATUS  16'hD152
`define DSP_DSP_CMD     16'hD160
`define DSP_DSP_BUSY    16'hD161
`define DSP_DSP_GEN_LO  16'hD162
`define DSP_DSP_GEN_HI  16'hD163
`define DSP_DSP_GEN     16'hD164
`define DSP_RX_COUNT    16'hD170
`define DSP_HOST_WORDS  12'hD10
`define DSP_DSP_WORDS   12'hD11

// ****************************************
// Host side byte addresses
// ****************************************
`define HB_DSP_WORDS    8'h20
`define HB_WORDS_END    8'h40
`define HB_HOST_CMD     8'h40
`define HB_HOST_BUSY    8'h41
`define HB_HOST_GEN_LO  8'h42
`define HB_HOST_GEN_HI  8'h43
`define HB_DSP_CMD      8'h60
`define HB_DSP_BUSY     8'h61
`define HB_DSP_GEN_LO   8'h62
`define HB_DSP_GEN_HI   8'h63

// ****************************************
// Field positions and reset values
// ****************************************
`define BUSY_BIT        15
`define BUSY_HB_BIT     7
`define STAT_TX_DONE    3
`define STAT_RX_DONE    2
`define STAT_TX_EN      1
`define STAT_RX_EN      0
`define COUNT_RESET     4'hF

`endif

// >>> core/mbox_dev_end.sv
// Device end of the mailbox: DSP port, host byte bus slave and DMA mailbox
//
// Contract
// - Host command byte, host writes, reset zero
// - Host command write sets host busy flag
// - DSP write to busy register clears it
// - Host writes command only while not busy; a host byte access write to it is taken even while busy
// - DSP command byte, DSP writes, reset zero
// - DSP command write sets DSP busy flag
// - Host write to DSP busy clears it
// - DSP writes command only while not busy
// - Host generic word written as two bytes
// - DSP generic word read as two bytes
// - Sixteen host words, upper eight DMA transmit
// - Sixteen DSP words, upper eight DMA receive
// - Transmit count write starts count+1 bytes
// - Transmit count decrements, ends and resets F
// - Receive count write starts count+1 bytes
// - Receive count decrements, ends and resets F
// - Status read clears completion flags
// - Transmit done flag in bit three
// - Receive done flag in bit two
// - Mask bits one and zero gate interrupts
`timescale 1ns/1ns

// ****************************************
// Device end
// ****************************************
module mbox_dev_end
    import mbox_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    // DSP register port
    input  wire logic        dsp_wr_i,
    input  wire logic        dsp_rd_i,
    input  wire logic [15:0] dsp_addr_i,
    input  wire logic [15:0] dsp_wdata_i,
    output logic [15:0]      dsp_rdata_o,
    output logic             dsp_irq_o,
    // Host link
    mbox_if.dev_end          link
);
`include "mbox_defines.svh"

    dev_state_t q, d;
    logic       fifo_in_ready;
    logic [7:0] push_byte;
    logic       push_fire;
    logic       pop_fire;
    logic       tx_fire;

    // Receive bytes leave the DSP words via the FIFO
    assign push_byte = q.dsp_words[{1'b1, q.rx_pidx[3:1]}][{q.rx_pidx[0], 3'b000} +: 8];
    assign push_fire = q.rx_push && fifo_in_ready;
    assign pop_fire  = link.dma_rx_valid && link.dma_rx_ready && q.rx_act;
    assign tx_fire   = q.tx_act && link.dma_tx_we;

    mbox_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk_i  (core_clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (q.rx_push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_byte),
        .out_valid_o (link.dma_rx_valid),
        .out_ready_i (link.dma_rx_ready),
        .out_data_o  (link.dma_rx_data)
    );

    // Outputs from the state register
    assign dsp_rdata_o     = q.dsp_rdata;
    assign link.hb_rdata   = q.host_rdata;
    assign link.dma_tx_req = q.tx_act;
    assign dsp_irq_o       = (q.tx_done && q.tx_en) || (q.rx_done && q.rx_en);

    // Next state; clears come first so a same-cycle set wins
    always_comb begin
        d = q;
        // DSP reads
        if (dsp_rd_i) begin
            d.dsp_rdata = 16'h0000;
            if (dsp_addr_i == `DSP_HOST_CMD) begin
                d.dsp_rdata = {8'h00, q.host_cmd};
            end else if (dsp_addr_i == `DSP_HOST_GEN) begin
                d.dsp_rdata = q.host_gen;
            end else if (dsp_addr_i == `DSP_HOST_GEN_HI) begin
                d.dsp_rdata = {8'h00, q.host_gen[15:8]};
            end else if (dsp_addr_i == `DSP_HOST_GEN_LO) begin
                d.dsp_rdata = {8'h00, q.host_gen[7:0]};
            end else if (dsp_addr_i == `DSP_DSP_BUSY) begin
                d.dsp_rdata[`BUSY_BIT] = q.dsp_busy;
            end else if (dsp_addr_i == `DSP_TX_COUNT) begin
                d.dsp_rdata = {12'h000, q.tx_cnt};
            end else if (dsp_addr_i == `DSP_RX_COUNT) begin
                d.dsp_rdata = {12'h000, q.rx_cnt};
            end else if (dsp_addr_i == `DSP_IRQ_STATUS) begin
                d.dsp_rdata[`STAT_TX_DONE] = q.tx_done;
                d.dsp_rdata[`STAT_RX_DONE] = q.rx_done;
                d.dsp_rdata[`STAT_TX_EN]   = q.tx_en;
                d.dsp_rdata[`STAT_RX_EN]   = q.rx_en;
                d.tx_done = 1'b0;
                d.rx_done = 1'b0;
            end else if (dsp_addr_i[15:4] == `DSP_HOST_WORDS) begin
                d.dsp_rdata = q.host_words[dsp_addr_i[3:0]];
            end
        end
        // Host byte reads
        if (link.hb_rd) begin
            d.host_rdata = 8'h00;
            if (link.hb_addr == `HB_HOST_BUSY) begin
                d.host_rdata[`BUSY_HB_BIT] = q.host_busy;
            end else if (link.hb_addr == `HB_DSP_CMD) begin
                d.host_rdata = q.dsp_cmd;
            end else if (link.hb_addr == `HB_DSP_BUSY) begin
                d.host_rdata[`BUSY_HB_BIT] = q.dsp_busy;
            end else if (link.hb_addr == `HB_DSP_GEN_HI) begin
                d.host_rdata = q.dsp_gen[15:8];
            end else if (link.hb_addr == `HB_DSP_GEN_LO) begin
                d.host_rdata = q.dsp_gen[7:0];
            end else if (link.hb_addr >= `HB_DSP_WORDS && link.hb_addr < `HB_WORDS_END) begin
                d.host_rdata = q.dsp_words[link.hb_addr[4:1]][{link.hb_addr[0], 3'b000} +: 8];
            end
        end
        // Host byte writes
        if (link.hb_wr) begin
            if (link.hb_addr == `HB_DSP_BUSY) begin
                d.dsp_busy = 1'b0;
            end else if (link.hb_addr == `HB_HOST_GEN_HI) begin
                d.host_gen[15:8] = link.hb_wdata;
            end else if (link.hb_addr == `HB_HOST_GEN_LO) begin
                d.host_gen[7:0] = link.hb_wdata;
            end else if (link.hb_addr < `HB_DSP_WORDS) begin
                d.host_words[link.hb_addr[4:1]][{link.hb_addr[0], 3'b000} +: 8] =
                    link.hb_wdata;
            end
        end
        // DMA writes into the upper host words
        if (tx_fire) begin
            d.host_words[{1'b1, q.tx_idx[3:1]}][{q.tx_idx[0], 3'b000} +: 8] = link.dma_tx_data;
            d.tx_idx = q.tx_idx + 4'h1;
            d.tx_cnt = q.tx_cnt - 4'h1;
            if (q.tx_cnt == 4'h0) begin
                d.tx_act  = 1'b0;
                d.tx_done = 1'b1;
            end
        end
        // Receive bytes into the FIFO
        if (push_fire) begin
            d.rx_pidx = q.rx_pidx + 4'h1;
            if (q.rx_pidx == q.rx_pend) begin
                d.rx_push = 1'b0;
            end
        end
        // Receive bytes taken by the host DMA
        if (pop_fire) begin
            d.rx_cnt = q.rx_cnt - 4'h1;
            if (q.rx_cnt == 4'h0) begin
                d.rx_act  = 1'b0;
                d.rx_done = 1'b1;
            end
        end
        // DSP writes
        if (dsp_wr_i) begin
            if (dsp_addr_i == `DSP_HOST_BUSY) begin
                d.host_busy = 1'b0;
            end else if (dsp_addr_i == `DSP_DSP_CMD) begin
                if (!q.dsp_busy) begin
                    d.dsp_cmd  = dsp_wdata_i[7:0];
                    d.dsp_busy = 1'b1;
                end
            end else if (dsp_addr_i == `DSP_DSP_GEN) begin
                d.dsp_gen = dsp_wdata_i;
            end else if (dsp_addr_i == `DSP_DSP_GEN_HI) begin
                d.dsp_gen[15:8] = dsp_wdata_i[7:0];
            end else if (dsp_addr_i == `DSP_DSP_GEN_LO) begin
                d.dsp_gen[7:0] = dsp_wdata_i[7:0];
            end else if (dsp_addr_i == `DSP_TX_COUNT) begin
                d.tx_cnt = dsp_wdata_i[3:0];
                d.tx_act = 1'b1;
                d.tx_idx = 4'h0;
            end else if (dsp_addr_i == `DSP_RX_COUNT) begin
                // A restart does not flush bytes already queued
                d.rx_cnt  = dsp_wdata_i[3:0];
                d.rx_act  = 1'b1;
                d.rx_push = 1'b1;
                d.rx_pidx = 4'h0;
                d.rx_pend = dsp_wdata_i[3:0];
            end else if (dsp_addr_i == `DSP_IRQ_STATUS) begin
                d.tx_en = dsp_wdata_i[`STAT_TX_EN];
                d.rx_en = dsp_wdata_i[`STAT_RX_EN];
            end else if (dsp_addr_i[15:4] == `DSP_DSP_WORDS) begin
                d.dsp_words[dsp_addr_i[3:0]] = dsp_wdata_i;
            end
        end
        // Host command last: its busy set beats a DSP clear
        if (link.hb_wr && link.hb_addr == `HB_HOST_CMD) begin
            d.host_cmd  = link.hb_wdata;
            d.host_busy = 1'b1;
        end
    end

    // State register; counters idle at F
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q        <= '0;
            q.tx_cnt <= `COUNT_RESET;
            q.rx_cnt <= `COUNT_RESET;
        end else begin
            q <= d;
        end
    end
endmodule : mbox_dev_end

// >>> core/mbox_host_end.sv
// Host end of the mailbox: command sender, byte access port and DMA streams
`timescale 1ns/1ns
module mbox_host_end
    import mbox_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    // Command request
    input  wire logic       cmd_valid_i,
    input  wire logic [7:0] cmd_i,
    output logic            cmd_ready_o,
    // Byte access request
    input  wire logic       acc_valid_i,
    input  wire logic       acc_write_i,
    input  wire logic [7:0] acc_addr_i,
    input  wire logic [7:0] acc_wdata_i,
    output logic            acc_ready_o,
    output logic            rd_valid_o,
    output logic [7:0]      rd_data_o,
    // DMA transmit source
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_ready_o,
    // DMA receive sink
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o,
    input  wire logic       rx_ready_i,
    // Device link
    mbox_if.host_end        link
);
`include "mbox_defines.svh"

    host_state_t q, d;
    logic        free;

    // Busy bit as answered to the poll
    assign free        = (q.st == H_CHECK) && !link.hb_rdata[`BUSY_HB_BIT];
    assign cmd_ready_o = free;
    assign acc_ready_o = (q.st == H_IDLE) && !cmd_valid_i;

    // Bus strobes from the state register
    assign link.hb_wr    = q.wr;
    assign link.hb_rd    = q.rd;
    assign link.hb_addr  = q.addr;
    assign link.hb_wdata = q.wdata;
    assign rd_valid_o    = q.rd_valid;
    assign rd_data_o     = q.rd_data;

    // DMA streams map straight onto the link
    assign tx_ready_o        = link.dma_tx_req;
    assign link.dma_tx_we    = tx_valid_i && link.dma_tx_req;
    assign link.dma_tx_data  = tx_data_i;
    assign rx_valid_o        = link.dma_rx_valid;
    assign rx_data_o         = link.dma_rx_data;
    assign link.dma_rx_ready = rx_ready_i;

    // Commands wait for a free mailbox; polling repeats while busy
    always_comb begin
        d          = q;
        d.wr       = 1'b0;
        d.rd       = 1'b0;
        d.rd_valid = 1'b0;
        case (q.st)
            H_IDLE: begin
                if (cmd_valid_i) begin
                    d.rd   = 1'b1;
                    d.addr = `HB_HOST_BUSY;
                    d.st   = H_POLL;
                end else if (acc_valid_i) begin
                    d.wr    = acc_write_i;
                    d.rd    = !acc_write_i;
                    d.addr  = acc_addr_i;
                    d.wdata = acc_wdata_i;
                    d.st    = acc_write_i ? H_IDLE : H_READ;
                end
            end
            H_POLL: begin
                d.st = H_CHECK;
            end
            H_CHECK: begin
                if (free) begin
                    d.wr    = 1'b1;
                    d.addr  = `HB_HOST_CMD;
                    d.wdata = cmd_i;
                    d.st    = H_IDLE;
                end else begin
                    d.rd = 1'b1;
                    d.st = H_POLL;
                end
            end
            H_READ: begin
                d.st = H_DATA;
            end
            H_DATA: begin
                d.rd_valid = 1'b1;
                d.rd_data  = link.hb_rdata;
                d.st       = H_IDLE;
            end
            default: begin
                d.st = H_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : mbox_host_end

// ****************************************
// Byte FIFO on the receive DMA path
// ****************************************
module mbox_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             resetn_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_state_t;

    fifo_state_t q, d;
    logic        push;
    logic        pop;

    // Flags straight from the fill count
    assign in_ready_o  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (q.cnt != '0);
    assign out_data_o  = q.mem[q.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Wrap handles depths that are not a power of two
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data_i;
            d.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : mbox_fifo

// >>> core/mbox_if.sv
// Byte bus and DMA byte streams between host and device ends
`timescale 1ns/1ns
interface mbox_if;
    logic       hb_wr;
    logic       hb_rd;
    logic [7:0] hb_addr;
    logic [7:0] hb_wdata;
    logic [7:0] hb_rdata;
    logic       dma_tx_req;
    logic       dma_tx_we;
    logic [7:0] dma_tx_data;
    logic       dma_rx_valid;
    logic       dma_rx_ready;
    logic [7:0] dma_rx_data;

    modport host_end (
        output hb_wr, hb_rd, hb_addr, hb_wdata, dma_tx_we, dma_tx_data, dma_rx_ready,
        input  hb_rdata, dma_tx_req, dma_rx_valid, dma_rx_data
    );
    modport dev_end (
        input  hb_wr, hb_rd, hb_addr, hb_wdata, dma_tx_we, dma_tx_data, dma_rx_ready,
        output hb_rdata, dma_tx_req, dma_rx_valid, dma_rx_data
    );
endinterface : mbox_if

// >>> core/mbox_pkg.sv
// State types of both mailbox ends
package mbox_pkg;

    // Device end state
    typedef struct packed {
        logic [7:0]        host_cmd;
        logic              host_busy;
        logic [15:0]       host_gen;
        logic [15:0][15:0] host_words;
        logic [7:0]        dsp_cmd;
        logic              dsp_busy;
        logic [15:0]       dsp_gen;
        logic [15:0][15:0] dsp_words;
        logic [3:0]        tx_cnt;
        logic              tx_act;
        logic [3:0]        tx_idx;
        logic [3:0]        rx_cnt;
        logic              rx_act;
        logic              rx_push;
        logic [3:0]        rx_pidx;
        logic [3:0]        rx_pend;
        logic              tx_done;
        logic              rx_done;
        logic              tx_en;
        logic              rx_en;
        logic [15:0]       dsp_rdata;
        logic [7:0]        host_rdata;
    } dev_state_t;

    // Host end sequencer states
    typedef enum logic [2:0] {
        H_IDLE,
        H_POLL,
        H_CHECK,
        H_READ,
        H_DATA
    } host_fsm_t;

    // Host end state
    typedef struct packed {
        host_fsm_t  st;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       rd_valid;
        logic [7:0] rd_data;
    } host_state_t;

endpackage : mbox_pkg

// >>> testbench/host_dsp_mailbox_dma_bench.sv
// Self-checking bench joining the host and device mailbox ends
`timescale 1ns/1ns
`include "mbox_defines.svh"
module host_dsp_mailbox_dma_bench;
    logic        core_clk_i, resetn_i, dsp_wr_i, dsp_rd_i, dsp_irq_o;
    logic [15:0] dsp_addr_i, dsp_wdata_i, dsp_rdata_o, w;
    logic        cmd_valid_i, cmd_ready_o, acc_valid_i, acc_write_i, acc_ready_o, rd_valid_o;
    logic [7:0]  cmd_i, acc_addr_i, acc_wdata_i, rd_data_o, tx_data_i, rx_data_o, b;
    logic        tx_valid_i, tx_ready_o, rx_valid_o, rx_ready_i;
    logic [15:0] hw [16];
    logic [15:0] dw [16];
    logic [7:0]  rxq [$];
    logic [31:0] rst_t [5] = '{32'hD1400000, 32'hD150000F, 32'hD170000F, 32'hD1520000,
                               32'hD1610000};
    integer      seed = 32'h7C9FEAA9;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          i, k, n;

    // Ends, link and checker
    mbox_if link ();
    mbox_dev_end #(.FIFO_DEPTH(4)) u_mbox_dev_end (.core_clk_i, .resetn_i, .dsp_wr_i,
        .dsp_rd_i, .dsp_addr_i, .dsp_wdata_i, .dsp_rdata_o, .dsp_irq_o, .link);
    mbox_host_end u_mbox_host_end (.core_clk_i, .resetn_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
        .acc_valid_i, .acc_write_i, .acc_addr_i, .acc_wdata_i, .acc_ready_o, .rd_valid_o,
        .rd_data_o, .tx_valid_i, .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o,
        .rx_ready_i, .link);
    mbox_link_sva u_mbox_link_sva (.core_clk_i, .resetn_i, .hb_wr(link.hb_wr),
        .hb_rd(link.hb_rd), .hb_addr(link.hb_addr), .hb_rdata(link.hb_rdata),
        .dma_tx_req(link.dma_tx_req), .dma_tx_we(link.dma_tx_we),
        .dma_rx_valid(link.dma_rx_valid), .dma_rx_ready(link.dma_rx_ready),
        .dma_rx_data(link.dma_rx_data));

    // 50 MHz clock
    always #10 core_clk_i = ~core_clk_i;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // A used-up wait bound ends the run
    task automatic tmo(input int j);
        if (j >= 200) begin
            n_mismatch++;
            final_report();
        end
    endtask : tmo
    task automatic dsp_wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge core_clk_i);
        {dsp_wr_i, dsp_addr_i, dsp_wdata_i} = {1'b1, a, d};
        @(negedge core_clk_i);
        dsp_wr_i = 1'b0;
    endtask : dsp_wr
    task automatic dsp_chk(input logic [15:0] a, input logic [15:0] e);
        @(negedge core_clk_i);
        {dsp_rd_i, dsp_addr_i} = {1'b1, a};
        @(negedge core_clk_i);
        dsp_rd_i = 1'b0;
        chk($sformatf("dsp %h", a), e, dsp_rdata_o);
    endtask : dsp_chk
    // Ready is combinational: look 1 ns after inputs move
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int j;
        @(negedge core_clk_i);
        {acc_valid_i, acc_write_i, acc_addr_i, acc_wdata_i} = {1'b1, wr, a, d};
        #1;
        for (j = 0; !acc_ready_o && j < 200; j++) #20;
        tmo(j);
        @(negedge core_clk_i);
        acc_valid_i = 1'b0;
        for (j = 0; !wr && !rd_valid_o && j < 200; j++) @(negedge core_clk_i);
        tmo(j);
    endtask : acc
    task automatic hrd(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk($sformatf("host %h", a), e, rd_data_o);
    endtask : hrd
    task automatic cmd_wait();
        int j;
        #1;
        for (j = 0; !cmd_ready_o && j < 200; j++) #20;
        tmo(j);
        @(negedge core_clk_i);
        cmd_valid_i = 1'b0;
    endtask : cmd_wait

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        {core_clk_i, resetn_i, dsp_wr_i, dsp_rd_i, dsp_addr_i, dsp_wdata_i} = '0;
        {cmd_valid_i, cmd_i, acc_valid_i, acc_write_i, acc_addr_i, acc_wdata_i} = '0;
        {tx_valid_i, tx_data_i, rx_ready_i} = '0;
        repeat (10) @(negedge core_clk_i);
        resetn_i = 1'b1;
        foreach (rst_t[j]) dsp_chk(rst_t[j][31:16], rst_t[j][15:0]);
        // Command, then a second one held until the DSP frees the box
        b = 8'($random(seed));
        {cmd_valid_i, cmd_i} = {1'b1, b};
        cmd_wait();
        hrd(`HB_HOST_BUSY, 8'h80);
        dsp_chk(`DSP_HOST_CMD, {8'h00, b});
        {cmd_valid_i, cmd_i} = {1'b1, ~b};
        repeat (12) begin #20; chk("cmd_ready_o", 1'b0, cmd_ready_o); end
        dsp_wr(`DSP_HOST_BUSY, 16'(seed));
        cmd_wait();
        dsp_chk(`DSP_HOST_CMD, {8'h00, ~b});
        // Second DSP command dropped while box taken
        dsp_wr(`DSP_DSP_CMD, {8'h00, b});
        dsp_wr(`DSP_DSP_CMD, {8'h00, ~b});
        hrd(`HB_DSP_CMD, b);
        hrd(`HB_DSP_BUSY, 8'h80);
        acc(1'b1, `HB_DSP_BUSY, b);
        hrd(`HB_DSP_BUSY, 8'h00);
        w = 16'($random(seed));
        acc(1'b1, `HB_HOST_GEN_LO, w[7:0]);
        acc(1'b1, `HB_HOST_GEN_HI, w[15:8]);
        dsp_chk(`DSP_HOST_GEN, w);
        dsp_chk(`DSP_HOST_GEN_HI, {8'h00, w[15:8]});
        dsp_wr(`DSP_DSP_GEN, ~w);
        hrd(`HB_DSP_GEN_LO, ~w[7:0]);
        hrd(`HB_DSP_GEN_HI, ~w[15:8]);
        for (n = 0; n < 16; n++) begin
            {hw[n], dw[n]} = $random(seed);
            acc(1'b1, 8'(2 * n), hw[n][7:0]);
            acc(1'b1, 8'(2 * n + 1), hw[n][15:8]);
            dsp_wr({`DSP_DSP_WORDS, 4'(n)}, dw[n]);
        end
        for (n = 0; n < 16; n++) begin
            dsp_chk({`DSP_HOST_WORDS, 4'(n)}, hw[n]);
            hrd(8'(`HB_DSP_WORDS + 2 * n), dw[n][7:0]);
            hrd(8'(`HB_DSP_WORDS + 2 * n + 1), dw[n][15:8]);
        end
        // Random-length transmit burst, hesitant source
        dsp_wr(`DSP_IRQ_STATUS, 16'h0003);
        n = $random(seed) & 15;
        k = 0;
        dsp_wr(`DSP_TX_COUNT, 16'(n));
        for (i = 0; k <= n && i < 200; i++) begin
            @(negedge core_clk_i);
            {tx_valid_i, tx_data_i} = 9'($random(seed));
            if (tx_valid_i && tx_ready_o) begin
                hw[8 + k / 2][8 * (k % 2) +: 8] = tx_data_i;
                k++;
            end
        end
        tmo(i);
        @(negedge core_clk_i);
        tx_valid_i = 1'b0;
        chk("dsp_irq_o", 1'b1, dsp_irq_o);
        dsp_chk(`DSP_TX_COUNT, 16'h000F);
        dsp_chk(`DSP_IRQ_STATUS, 16'h000B);
        chk("dsp_irq_o", 1'b0, dsp_irq_o);
        dsp_chk(`DSP_IRQ_STATUS, 16'h0003);
        for (n = 8; n < 16; n++) dsp_chk({`DSP_HOST_WORDS, 4'(n)}, hw[n]);
        // Receive burst into a stalling sink
        dsp_wr(`DSP_IRQ_STATUS, 16'h0002);
        for (k = 0; k < 16; k++) rxq.push_back(dw[8 + k / 2][8 * (k % 2) +: 8]);
        dsp_wr(`DSP_RX_COUNT, 16'h000F);
        repeat (12) @(negedge core_clk_i);
        chk("rx_valid_o", 1'b1, rx_valid_o);
        for (i = 0; rxq.size() > 0 && i < 400; i++) begin
            @(negedge core_clk_i);
            rx_ready_i = 1'($random(seed));
            if (rx_valid_o && rx_ready_i) chk("rx_data_o", rxq.pop_front(), rx_data_o);
        end
        tmo(i / 2);
        @(negedge core_clk_i);
        rx_ready_i = 1'b0;
        chk("rx_valid_o", 1'b0, rx_valid_o);
        chk("dsp_irq_o", 1'b0, dsp_irq_o);
        dsp_chk(`DSP_RX_COUNT, 16'h000F);
        dsp_chk(`DSP_IRQ_STATUS, 16'h0006);
        hrd(8'h7E, 8'h00);
        final_report();
    end
endmodule : host_dsp_mailbox_dma_bench

// >>> testbench/mbox_link_sva.sv
// Checker of the byte bus and DMA streams between the two mailbox ends
`timescale 1ns/1ns
module mbox_link_sva (
    // Clock and reset
    input wire logic       core_clk_i,
    input wire logic       resetn_i,
    // Byte bus
    input wire logic       hb_wr,
    input wire logic       hb_rd,
    input wire logic [7:0] hb_addr,
    input wire logic [7:0] hb_rdata,
    // DMA streams
    input wire logic       dma_tx_req,
    input wire logic       dma_tx_we,
    input wire logic       dma_rx_valid,
    input wire logic       dma_rx_ready,
    input wire logic [7:0] dma_rx_data
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    logic [4:0] tx_seen_q;
    logic [4:0] tx_seen_d;

    // Running burst bytes; no saturation, so overruns show
    always_comb begin
        tx_seen_d = dma_tx_req ? tx_seen_q + 5'(dma_tx_we) : 5'h00;
    end

    // Burst byte register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_seen_q <= 5'h00;
        end else begin
            tx_seen_q <= tx_seen_d;
        end
    end

    // ****************************************
    // Sequences and properties
    // ****************************************
    sequence s_release;
        hb_wr && hb_addr == 8'h61 ##[1:4] hb_rd && hb_addr == 8'h61;
    endsequence
    sequence s_stall;
        dma_rx_valid && !dma_rx_ready;
    endsequence
    property p_cmd_after_poll;
        hb_wr && hb_addr == 8'h40 |->
            $past(hb_rd, 2) && $past(hb_addr, 2) == 8'h41 && !$past(hb_rdata[7]);
    endproperty
    property p_busy_release;
        s_release |=> !hb_rdata[7];
    endproperty
    property p_rdata_stands;
        !hb_rd |=> $stable(hb_rdata);
    endproperty
    property p_unmapped;
        hb_rd && hb_addr >= 8'h70 |=> hb_rdata == 8'h00;
    endproperty
    property p_tx_we_req;
        dma_tx_req && !dma_tx_we |=> dma_tx_req;
    endproperty
    property p_tx_len;
        tx_seen_q <= 5'h10;
    endproperty
    property p_tx_end;
        $fell(dma_tx_req) |-> $past(dma_tx_we);
    endproperty
    property p_rx_hold;
        s_stall |=> dma_rx_valid && $stable(dma_rx_data);
    endproperty

    a_cmd_after_poll: assert property (p_cmd_after_poll) else $error("command not after free poll");
    a_busy_release: assert property (p_busy_release) else $error("busy not released");
    a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_tx_we_req: assert property (p_tx_we_req) else $error("request withdrawn");
    a_tx_len: assert property (p_tx_len) else $error("burst too long");
    a_tx_end: assert property (p_tx_end) else $error("request dropped early");
    a_rx_hold: assert property (p_rx_hold) else $error("stalled byte lost");
endmodule : mbox_link_sva
